//--- src/pcld_top.sv
// digital control of a four-channel pulse-count dimmed LED sink driver
`timescale 1ns/1ps
// Notes on behaviour
// - a first high from shutdown enables all channels at 25 mA.
// - each later rise while on lowers the current by 1/31 of full scale, except a rise at zero, which returns it to full scale.
// - step 30 gives the lowest nonzero level, 31 zero, 32 full scale.
// - current is full scale times (31 - n) / 31 for n steps taken.
// - there are 32 levels, chosen only by pulsing the enable pin.
// - pulse counts 1, 30, 31, 32 give about 97, 3, 0, 100 percent.
// - a low as long as the timeout shuts down and forgets the level.
// - lows below the minimum low time are filtered and do not step.
// - lows above the maximum low time may end in shutdown instead.
// - supply lockout switches all channels off and resets the level.
// - in shutdown every sink output is high impedance.
// - one pin both enables the device and carries the stepping pulses.
// - the shutdown timeout lies between 2 ms and 5 ms, nominally 3 ms.
module pcld_top
  import pcld_pkg::*;
#(
  parameter int SHDN_CYCLES = SHDN_CYC,
  parameter int FILT_CYCLES = GLITCH_CYC
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  input  wire logic              enable_dim_input_i,
  input  wire logic              supply_lockout_i,
  output logic [NUM_CH-1:0]      led_sink_output_en_o,
  output logic [LEVEL_W-1:0]     dim_level_o
);
  localparam int             SW        = $clog2(SHDN_CYCLES + 1);
  localparam logic [SW-1:0]  SHDN_LAST = SW'(SHDN_CYCLES - 1);

  pcld_filt_if flt ();

  pcld_state_e        state_reg;
  pcld_state_e        state_next;
  logic [LEVEL_W-1:0] count_reg;
  logic [LEVEL_W-1:0] count_next;
  logic [SW-1:0]      lo_cnt_reg;
  logic [SW-1:0]      lo_cnt_next;
  logic [1:0]         lock_sync_reg;
  logic [1:0]         lock_sync_next;
  logic [NUM_CH-1:0]  en_reg;
  logic [NUM_CH-1:0]  en_next;
  logic [LEVEL_W-1:0] level_reg;
  logic [LEVEL_W-1:0] level_next;
  logic               lock;
  logic               timeout;

  // brightness code from the number of steps taken since enabling
  function automatic logic [LEVEL_W-1:0] level_of(
    input logic [LEVEL_W-1:0] steps
  );
    return LEVEL_FULL - steps;
  endfunction

  // the single pin is synchronised and filtered before any use
  pcld_pin_filter #(
    .FILT_CYC (FILT_CYCLES)
  ) u_filter (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (enable_dim_input_i),
    .flt       (flt.src)
  );

  assign lock    = lock_sync_reg[1];
  assign timeout = !flt.level && (lo_cnt_reg == SHDN_LAST);

  // power state, step counter and low-time counter
  always_comb begin
    lock_sync_next = {lock_sync_reg[0], supply_lockout_i};
    state_next     = state_reg;
    count_next     = count_reg;
    lo_cnt_next    = '0;
    case (state_reg)
      PCLD_OFF: begin
        if (flt.rise) begin
          state_next = PCLD_ON;
          count_next = COUNT_RST;
        end
      end
      PCLD_ON: begin
        if (timeout) begin
          state_next = PCLD_OFF;
          count_next = COUNT_RST;
        end else if (!flt.level) begin
          // the low-time clock only runs while the filtered pin is low
          lo_cnt_next = lo_cnt_reg + 1'b1;
        end else if (flt.rise) begin
          // 5-bit wrap: step 31 gives zero, step 32 full scale again
          count_next = count_reg + 1'b1;
        end
      end
      default: begin
        state_next = PCLD_OFF;
        count_next = COUNT_RST;
      end
    endcase
    // lockout wins over everything and restores defaults
    if (lock) begin
      state_next  = PCLD_OFF;
      count_next  = COUNT_RST;
      lo_cnt_next = '0;
    end
  end

  // outputs are registered copies of the next state, so they never lag
  always_comb begin
    if (state_next == PCLD_ON) begin
      en_next    = {NUM_CH{1'b1}};
      level_next = level_of(count_next);
    end else begin
      en_next    = '0;
      level_next = LEVEL_ZERO;
    end
  end

  // registers only
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg     <= PCLD_OFF;
      count_reg     <= COUNT_RST;
      lo_cnt_reg    <= '0;
      lock_sync_reg <= SYNC_RST;
      en_reg        <= '0;
      level_reg     <= LEVEL_ZERO;
    end else begin
      state_reg     <= state_next;
      count_reg     <= count_next;
      lo_cnt_reg    <= lo_cnt_next;
      lock_sync_reg <= lock_sync_next;
      en_reg        <= en_next;
      level_reg     <= level_next;
    end
  end

  assign led_sink_output_en_o = en_reg;
  assign dim_level_o          = level_reg;

  sequence s_enable_edge;
    (state_reg == PCLD_OFF) && flt.rise && !lock;
  endsequence

  sequence s_step_edge;
    (state_reg == PCLD_ON) && flt.rise && !lock;
  endsequence

  property p_enable;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      s_enable_edge
        |=> (en_reg == {NUM_CH{1'b1}}) && (level_reg == LEVEL_FULL);
  endproperty
  a_enable: assert property (p_enable)
    else $error("enable did not start at full scale");

  property p_step;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      s_step_edge ##0 (level_reg != LEVEL_ZERO)
        |=> level_reg == $past(level_reg) - 5'h01;
  endproperty
  a_step: assert property (p_step)
    else $error("rising edge did not lower the level by one step");

  property p_wrap;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      s_step_edge ##0 (level_reg == LEVEL_ZERO) |=> level_reg == LEVEL_FULL;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("step after zero did not return to full scale");

  property p_formula;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      en_reg[0] |-> level_reg == level_of(count_reg);
  endproperty
  a_formula: assert property (p_formula)
    else $error("level does not match the step count");

  property p_timeout;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state_reg == PCLD_ON) && timeout
        |=> (en_reg == '0) ##1 (count_reg == COUNT_RST);
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("long low did not shut down and clear the level");

  property p_hold_low;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state_reg == PCLD_ON) && !flt.level && !lock && !timeout
        |=> (state_reg == PCLD_ON) && $stable(level_reg);
  endproperty
  a_hold_low: assert property (p_hold_low)
    else $error("low below the timeout changed the state");

  property p_lockout;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      lock |=> (en_reg == '0) && (count_reg == COUNT_RST);
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("lockout left channels on or level kept");

  property p_hiz;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state_reg == PCLD_OFF) |-> (en_reg == '0) && (level_reg == LEVEL_ZERO);
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("sink enabled while in shutdown");

  // while on and without timeout or lockout, the level moves only on an accepted pulse
  property p_only_pulse;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state_reg == PCLD_ON) && !flt.rise && !lock && !timeout
        |=> $stable(count_reg);
  endproperty
  a_only_pulse: assert property (p_only_pulse)
    else $error("step count changed without a pulse");

  // five-bit wrap: a step from 31 must come back to 0, not saturate
  property p_count_wrap;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      s_step_edge |=> count_reg == $past(count_reg) + 5'h01;
  endproperty
  a_count_wrap: assert property (p_count_wrap)
    else $error("step count did not advance by one with wrap");
endmodule

//--- src/pcld_pkg.sv
// shared constants and types of the pulse-count LED dimmer
package pcld_pkg;
  // system clock rate
  localparam int CLK_FREQ_MHZ = 200;
  // shortest accepted level on the enable pin, and its cycle count
  localparam int GLITCH_NS  = 200;
  localparam int GLITCH_CYC = (GLITCH_NS * CLK_FREQ_MHZ + 999) / 1000;
  // continuous low time that forces shutdown (nominal), and its cycles
  localparam int SHDN_US  = 3000;
  localparam int SHDN_CYC = SHDN_US * CLK_FREQ_MHZ;
  // brightness code: 31 is full scale, 0 is zero current
  localparam int              LEVEL_W       = 5;
  localparam logic [4:0]      LEVEL_FULL    = 5'h1f;
  localparam logic [4:0]      LEVEL_ZERO    = 5'h00;
  localparam logic [4:0]      COUNT_RST     = 5'h00;
  localparam int              FULL_SCALE_MA = 25;
  localparam int              NUM_CH        = 4;
  localparam logic [1:0]      SYNC_RST      = 2'h0;
  // device power state
  typedef enum logic {PCLD_OFF, PCLD_ON} pcld_state_e;
endpackage

//--- src/pcld_filt_if.sv
// filtered enable pin level and rising-edge event between the modules
`timescale 1ns/1ps
interface pcld_filt_if;
  logic level;
  logic rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface

//--- src/pcld_pin_filter.sv
// synchroniser and glitch filter for the enable and dimming pin
`timescale 1ns/1ps
module pcld_pin_filter
  import pcld_pkg::*;
#(
  parameter int FILT_CYC = GLITCH_CYC
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  pcld_filt_if.src  flt
);
  localparam int             CW       = $clog2(FILT_CYC + 1);
  localparam logic [CW-1:0]  CNT_LAST = CW'(FILT_CYC - 1);

  logic [1:0]    sync_reg;
  logic [1:0]    sync_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          level_reg;
  logic          level_next;
  logic          rise_reg;
  logic          rise_next;

  // a new level is taken only after it held for FILT_CYC samples, so
  // short lows never count as a dimming step
  always_comb begin
    sync_next  = {sync_reg[0], pin_i};
    cnt_next   = '0;
    level_next = level_reg;
    rise_next  = 1'b0;
    if (sync_reg[1] != level_reg) begin
      if (cnt_reg == CNT_LAST) begin
        level_next = sync_reg[1];
        rise_next  = sync_reg[1];
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  // registers only
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_reg  <= SYNC_RST;
      cnt_reg   <= '0;
      level_reg <= 1'b0;
      rise_reg  <= 1'b0;
    end else begin
      sync_reg  <= sync_next;
      cnt_reg   <= cnt_next;
      level_reg <= level_next;
      rise_reg  <= rise_next;
    end
  end

  assign flt.level = level_reg;
  assign flt.rise  = rise_reg;

  // a low shorter than the filter time leaves the level high
  property p_no_glitch;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      level_reg && !sync_reg[1] && (cnt_reg != CNT_LAST) |=> level_reg;
  endproperty
  a_no_glitch: assert property (p_no_glitch)
    else $error("short low pulse changed the filtered level");

  // the rise event is one cycle long and marks a new high level
  property p_rise_pulse;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      rise_reg |-> level_reg && $past(sync_reg[1]) ##1 !rise_reg;
  endproperty
  a_rise_pulse: assert property (p_rise_pulse)
    else $error("rise event not a single cycle at a high level");
endmodule

//--- verif/pcld_host_model.sv
// host model that drives the enable and dimming pin of the dimmer
`timescale 1ns/1ps
module pcld_host_model (
  input  wire logic clk_sys_i,
  output logic      pin_o
);
  // pin has a pull-down, so an idle host leaves it low
  initial pin_o = 1'b0;

  // hold one level for a number of cycles, changing after falling edges
  task automatic drive(input logic lvl, input int cyc);
    @(negedge clk_sys_i);
    pin_o = lvl;
    repeat (cyc - 1) @(negedge clk_sys_i);
  endtask

  // one stepping pulse; both widths stay above the filter length
  task automatic step(input int lo, input int hi);
    drive(1'b0, lo);
    drive(1'b1, hi);
  endtask
endmodule

//--- verif/tb.sv
// self-checking testbench of the pulse-count LED dimmer
`timescale 1ns/1ps
module tb;
  import pcld_pkg::*;
  // short counts keep the run brief; expectations scale with them
  localparam int SHD = 200;
  localparam int FLT = 4;
  logic               clk_sys_i        = 1'b0;
  logic               rst_n_i          = 1'b0;
  logic               supply_lockout_i = 1'b0;
  logic               pin;
  logic [NUM_CH-1:0]  en_o;
  logic [LEVEL_W-1:0] level_o;
  int                 bad_count        = 0;
  int                 checked          = 0;
  int                 n;

  // 200 MHz system clock
  always #2.5 clk_sys_i = ~clk_sys_i;

  pcld_host_model host (.clk_sys_i(clk_sys_i), .pin_o(pin));

  pcld_top #(.SHDN_CYCLES(SHD), .FILT_CYCLES(FLT)) dut (
    .clk_sys_i           (clk_sys_i),
    .rst_n_i             (rst_n_i),
    .enable_dim_input_i  (pin),
    .supply_lockout_i    (supply_lockout_i),
    .led_sink_output_en_o(en_o),
    .dim_level_o         (level_o)
  );

  // compare one value and count the result
  task automatic chk(input string what, input logic [4:0] seen,
                     input logic [4:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // code after a number of steps; wraps mod 32 so 31 gives 0, 32 full
  function automatic logic [4:0] lvl_of(input int steps);
    return 5'(31 - steps);
  endfunction

  // wait a bounded time for the answer, then compare both outputs
  task automatic settle(input logic [4:0] exp_lvl, input logic exp_on);
    int k;
    k = 0;
    while (k < 20 && (level_o !== exp_lvl || en_o !== {NUM_CH{exp_on}})) begin
      @(negedge clk_sys_i);
      k++;
    end
    chk("level", level_o, exp_lvl);
    chk("enable", {1'b0, en_o}, {1'b0, {NUM_CH{exp_on}}});
  endtask

  // verdict and end of run
  task automatic end_sim;
    if (bad_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // watchdog against a hung sequence
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    bad_count++;
    end_sim();
  end

  // main sequence
  initial begin
    n = $urandom(77);
    repeat (4) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    settle(LEVEL_ZERO, 1'b0);
    host.drive(1'b1, 12);
    settle(LEVEL_FULL, 1'b1);
    // all 32 levels and the wrap, with random pulse widths
    for (int i = 1; i <= 33; i++) begin
      host.step(6 + $urandom_range(30), 10 + $urandom_range(10));
      settle(lvl_of(i), 1'b1);
    end
    n = 33;
    // a low shorter than the filter must not step
    host.drive(1'b0, 2);
    host.drive(1'b1, 12);
    repeat (10) @(negedge clk_sys_i);
    settle(lvl_of(n), 1'b1);
    // shortest safe low still steps
    host.step(FLT + 1, 12);
    n++;
    settle(lvl_of(n), 1'b1);
    // a long low below the timeout counts as one step
    // a high shorter than the filter inside that low is ignored too
    host.drive(1'b0, 70);
    host.drive(1'b1, 2);
    host.drive(1'b0, 78);
    host.drive(1'b1, 12);
    n++;
    settle(lvl_of(n), 1'b1);
    // no shutdown before the minimum timeout, then off and forgotten
    host.drive(1'b0, 120);
    chk("early", level_o, lvl_of(n));
    host.drive(1'b0, SHD);
    settle(LEVEL_ZERO, 1'b0);
    host.drive(1'b1, 12);
    settle(LEVEL_FULL, 1'b1);
    // lockout clears the level and ignores pulses while held
    host.step(6, 12);
    settle(lvl_of(1), 1'b1);
    supply_lockout_i = 1'b1;
    settle(LEVEL_ZERO, 1'b0);
    host.step(6, 12);
    repeat (10) @(negedge clk_sys_i);
    settle(LEVEL_ZERO, 1'b0);
    supply_lockout_i = 1'b0;
    host.drive(1'b0, 10);
    host.drive(1'b1, 12);
    settle(LEVEL_FULL, 1'b1);
    // reset in mid-run with the pin high re-enables at full scale
    host.step(6, 12);
    settle(lvl_of(1), 1'b1);
    rst_n_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    chk("in_reset", level_o, LEVEL_ZERO);
    rst_n_i = 1'b1;
    settle(LEVEL_FULL, 1'b1);
    end_sim();
  end
endmodule
